// File: hw/tcs_cfg.svh
// Register indices, reset values, field positions and divide ratios of the timer clock selector.
`ifndef TCS_CFG_SVH
`define TCS_CFG_SVH

// Register indices; the byte address on the bus is four times the index.
`define TCS_CLK_CTRL_IDX  8'h8E
`define TCS_MODE_IDX      8'h8F
`define TCS_COUNT_IDX     8'h90

// Reset values.
`define TCS_CLK_CTRL_RST  8'h00
`define TCS_MODE_RST      8'h00

// Field positions in the clock control register.
`define TCS_T0_SEL_BIT    2
`define TCS_T1_SEL_BIT    3
`define TCS_T2_LOW_BIT    4
`define TCS_T2_HIGH_BIT   5
`define TCS_T3_LOW_BIT    6
`define TCS_T3_HIGH_BIT   7

// Prescaler ratios in system clock cycles.
`define TCS_DIV_A         6'h0C
`define TCS_DIV_B         6'h04
`define TCS_DIV_C         6'h30

// Oscillator divider: a tick on every eighth rising edge.
`define TCS_OSC_DIV_LAST  3'h7

`endif

// File: hw/tcs_pkg.sv
// Types shared by the timer clock selector.
`default_nettype none

package tcs_pkg;

  // Prescaler code of the Timer 0/1 divider select field.
  typedef enum logic [1:0] {
    TCS_SCALE_12  = 2'h0,
    TCS_SCALE_4   = 2'h1,
    TCS_SCALE_48  = 2'h2,
    TCS_SCALE_EXT = 2'h3
  } tcs_scale_t;

  // Alternate clock choice of Timer 2 and Timer 3.
  typedef enum logic [1:0] {
    TCS_ALT_DIV12 = 2'h0,
    TCS_ALT_OSC8  = 2'h1,
    TCS_ALT_CMP   = 2'h2,
    TCS_ALT_RSVD  = 2'h3
  } tcs_alt_t;

  // Clock control register, most significant bit first.
  typedef struct packed {
    logic       timer3_high_clock_select;
    logic       timer3_low_clock_select;
    logic       timer2_high_clock_select;
    logic       timer2_low_clock_select;
    logic       timer1_clock_select;
    logic       timer0_clock_select;
    tcs_scale_t clock_divider_select;
  } tcs_ctrl_t;

  // Mode register, most significant bit first.
  typedef struct packed {
    tcs_alt_t timer3_alternate_clock_choice;
    tcs_alt_t timer2_alternate_clock_choice;
    logic     timer3_split;
    logic     timer2_split;
    logic     timer1_count_mode;
    logic     timer0_count_mode;
  } tcs_mode_t;

  // Count enables handed to the four timers.
  typedef struct packed {
    logic t0;
    logic t1;
    logic t2_low;
    logic t2_high;
    logic t3_low;
    logic t3_high;
  } tcs_ticks_t;

endpackage : tcs_pkg
`default_nettype wire

// File: hw/tcs_sync_edge.sv
// Two-stage synchroniser with rising and falling edge pulses.
`timescale 1ns/10ps
`default_nettype none

module tcs_sync_edge (
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic ce,
  // Asynchronous pin
  input  wire logic pin_in,
  // Edge pulses, one cycle each
  output logic      rise,
  output logic      fall
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  // The first stage feeds only the second stage; edges compare stage two and three.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else if (ce) begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Gated by the enable so a frozen block does not repeat a pulse.
  assign rise = ce & sync_q & ~prev_q;
  assign fall = ce & ~sync_q & prev_q;

  a_fall_single : assert property (@(posedge clk) disable iff (!arst_n)
    fall |=> !fall)
    else $error("falling edge pulse lasted more than one cycle");

endmodule : tcs_sync_edge
`default_nettype wire

// File: hw/tcs_timer_clock_select.sv
// Clock source selection and prescaling for four counter/timers with an Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
`include "tcs_cfg.svh"

// Behaviour
// - Timers 0 and 1 each take one of five sources set by their select bit and the divider field.
// - The shared prescaled clock is the system clock over 12, 4 or 48 for codes 00, 01 and 10.
// - Timers 0 and 1 choose between prescaled and system clock each on its own.
// - The Timer 0 select bit 2 picks prescaled at 0 and system clock at 1, ignored in count mode.
// - Timers 2 and 3 may both run from the system clock or the system clock over 12.
// - Timer 2 may also run from the real-time oscillator over 8 or comparator 0.
// - Timer 3 may also run from the external oscillator over 8 or comparator 1.
// - In split mode the high-byte bits 5 and 7 pick system clock at 1, else the alternate clock.
// - A timer in count mode advances once per falling edge on its event pin.
// - Events up to a quarter of the system clock rate are counted correctly.
// - With the Timer 0 count mode bit at 1 its pin drives it, at 0 its selected clock does.
module tcs_timer_clock_select #(
  parameter int ADDR_W  = 12,
  parameter int COUNT_W = 16
) (
  // Clock, reset and freeze
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              ce,
  // Avalon-MM slave, byte addressed
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  // Asynchronous clock and event inputs
  input  wire logic              timer0_event_pin,
  input  wire logic              timer1_event_pin,
  input  wire logic              ext_osc_clk,
  input  wire logic              rtc_osc_clk,
  input  wire logic              cmp0_out,
  input  wire logic              cmp1_out,
  // Count enables for the timers
  output tcs_pkg::tcs_ticks_t    ticks
);

  // Refuse widths that cannot hold the map or the readback.
  generate
    if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr
      $error("ADDR_W must lie between 10 and 32");
    end
    if (COUNT_W < 1 || COUNT_W > 16) begin : g_bad_count
      $error("COUNT_W must lie between 1 and 16");
    end
  endgenerate

  localparam logic [ADDR_W-1:0] A_CTRL  = ADDR_W'({`TCS_CLK_CTRL_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] A_MODE  = ADDR_W'({`TCS_MODE_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] A_COUNT = ADDR_W'({`TCS_COUNT_IDX, 2'b00});

  tcs_pkg::tcs_ctrl_t ctrl_q;
  tcs_pkg::tcs_mode_t mode_q;
  logic               ack_q;
  logic [31:0]        rdata_q;
  logic [5:0]         pre_cnt_q;
  logic [2:0]         ext_cnt_q;
  logic [2:0]         rtc_cnt_q;
  logic [COUNT_W-1:0] cnt0_q;
  logic [COUNT_W-1:0] cnt1_q;
  logic [COUNT_W-1:0] cnt0_d;
  logic [COUNT_W-1:0] cnt1_d;

  // Synchronised edges: 0 and 1 event pins, 2 external, 3 real-time, 4 and 5 comparators.
  logic [5:0] pins;
  logic [5:0] ev_rise;
  logic [5:0] ev_fall;
  assign pins = {cmp1_out, cmp0_out, rtc_osc_clk, ext_osc_clk, timer1_event_pin,
                 timer0_event_pin};

  // Every outside input passes the same synchroniser, so all sources share one latency.
  generate
    for (genvar i = 0; i < 6; i++) begin : g_sync
      tcs_sync_edge u_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .ce     (ce),
        .pin_in (pins[i]),
        .rise   (ev_rise[i]),
        .fall   (ev_fall[i])
      );
    end
  endgenerate

  // Bus decode; one wait cycle per access keeps read data on a flip-flop.
  wire req       = read | write;
  wire sel_ctrl  = (address == A_CTRL);
  wire sel_mode  = (address == A_MODE);
  wire sel_count = (address == A_COUNT);
  wire done      = req & ack_q & ce;
  wire wr_ctrl   = done & write & sel_ctrl & byteenable[0];
  wire wr_mode   = done & write & sel_mode & byteenable[0];
  wire cnt_clr   = done & write & sel_count;
  assign waitrequest = req & ~(ack_q & ce);
  assign readdata    = rdata_q;

  // Read mux; unmapped addresses read as zero and ignore writes.
  wire [31:0] rd_mux = sel_ctrl  ? {24'h000000, ctrl_q} :
                       sel_mode  ? {24'h000000, mode_q} :
                       sel_count ? {16'(cnt1_q), 16'(cnt0_q)} : 32'h00000000;

  // Handshake and register state.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h00000000;
      ctrl_q  <= `TCS_CLK_CTRL_RST;
      mode_q  <= `TCS_MODE_RST;
    end else if (ce) begin
      ack_q <= req & ~ack_q;
      if (read && !ack_q) begin
        rdata_q <= rd_mux;
      end
      if (wr_ctrl) begin
        ctrl_q <= writedata[7:0];
      end
      if (wr_mode) begin
        mode_q <= writedata[7:0];
      end
    end
  end

  // One free-running counter serves all three system clock ratios.
  wire [5:0] pre_last = `TCS_DIV_C - 6'h01;
  wire       p12 = ce & ((pre_cnt_q % `TCS_DIV_A) == (`TCS_DIV_A - 6'h01));
  wire       p4  = ce & ((pre_cnt_q % `TCS_DIV_B) == (`TCS_DIV_B - 6'h01));
  wire       p48 = ce & (pre_cnt_q == pre_last);

  // Oscillator dividers count synchronised rising edges, so each oscillator
  // must run at no more than a quarter of the system clock for every edge to be seen.
  wire ext8 = ev_rise[2] & (ext_cnt_q == `TCS_OSC_DIV_LAST);
  wire rtc8 = ev_rise[3] & (rtc_cnt_q == `TCS_OSC_DIV_LAST);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_cnt_q <= 6'h00;
      ext_cnt_q <= 3'h0;
      rtc_cnt_q <= 3'h0;
    end else if (ce) begin
      pre_cnt_q <= (pre_cnt_q == pre_last) ? 6'h00 : pre_cnt_q + 6'h01;
      ext_cnt_q <= ext_cnt_q + {2'b00, ev_rise[2]};
      rtc_cnt_q <= rtc_cnt_q + {2'b00, ev_rise[3]};
    end
  end

  // Shared Timer 0/1 prescaled clock.
  wire pre_tick =
    (ctrl_q.clock_divider_select == tcs_pkg::TCS_SCALE_12) ? p12 :
    (ctrl_q.clock_divider_select == tcs_pkg::TCS_SCALE_4)  ? p4  :
    (ctrl_q.clock_divider_select == tcs_pkg::TCS_SCALE_48) ? p48 : ext8;

  // Timer 0/1: event pin in count mode, else system clock or prescaled clock.
  assign ticks.t0 = mode_q.timer0_count_mode ? ev_fall[0] :
                    (ctrl_q.timer0_clock_select ? ce : pre_tick);
  assign ticks.t1 = mode_q.timer1_count_mode ? ev_fall[1] :
                    (ctrl_q.timer1_clock_select ? ce : pre_tick);

  // Alternate clocks; the reserved choice falls back to the system clock over 12.
  wire t2_alt = (mode_q.timer2_alternate_clock_choice == tcs_pkg::TCS_ALT_OSC8) ? rtc8 :
                (mode_q.timer2_alternate_clock_choice == tcs_pkg::TCS_ALT_CMP)  ? ev_rise[4] :
                p12;
  wire t3_alt = (mode_q.timer3_alternate_clock_choice == tcs_pkg::TCS_ALT_OSC8) ? ext8 :
                (mode_q.timer3_alternate_clock_choice == tcs_pkg::TCS_ALT_CMP)  ? ev_rise[5] :
                p12;

  // Timer 2/3 bytes: the high byte follows the low byte unless the timer is split.
  assign ticks.t2_low  = ctrl_q.timer2_low_clock_select ? ce : t2_alt;
  assign ticks.t3_low  = ctrl_q.timer3_low_clock_select ? ce : t3_alt;
  assign ticks.t2_high = mode_q.timer2_split ?
                         (ctrl_q.timer2_high_clock_select ? ce : t2_alt) :
                         ticks.t2_low;
  assign ticks.t3_high = mode_q.timer3_split ?
                         (ctrl_q.timer3_high_clock_select ? ce : t3_alt) :
                         ticks.t3_low;

  // Event tallies in count mode; an edge in the clearing cycle is kept as one count.
  wire inc0 = mode_q.timer0_count_mode & ev_fall[0];
  wire inc1 = mode_q.timer1_count_mode & ev_fall[1];
  assign cnt0_d = cnt_clr ? COUNT_W'(inc0) : cnt0_q + COUNT_W'(inc0);
  assign cnt1_d = cnt_clr ? COUNT_W'(inc1) : cnt1_q + COUNT_W'(inc1);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt0_q <= '0;
      cnt1_q <= '0;
    end else if (ce) begin
      cnt0_q <= cnt0_d;
      cnt1_q <= cnt1_d;
    end
  end

  // Checks on the selection, prescaling, event tally and bus handshake paths.
  a_div12_gap : assert property (@(posedge clk) disable iff (!arst_n)
    p12 |=> !p12 [*8])
    else $error("divide by 12 pulse came too early");

  a_div4_gap : assert property (@(posedge clk) disable iff (!arst_n)
    p4 |=> !p4 [*3])
    else $error("divide by 4 pulse came too early");

  a_div48_gap : assert property (@(posedge clk) disable iff (!arst_n)
    p48 |=> !p48 [*8])
    else $error("divide by 48 pulse came too early");

  a_pre_ext : assert property (@(posedge clk) disable iff (!arst_n)
    (ctrl_q.clock_divider_select == tcs_pkg::TCS_SCALE_EXT) |-> (pre_tick == ext8))
    else $error("code 11 did not select the external oscillator over eight");

  a_t0_sysclk : assert property (@(posedge clk) disable iff (!arst_n)
    (ce && !mode_q.timer0_count_mode && ctrl_q.timer0_clock_select) |-> ticks.t0)
    else $error("timer 0 missed a system clock tick");

  a_t1_prescale : assert property (@(posedge clk) disable iff (!arst_n)
    (!mode_q.timer1_count_mode && !ctrl_q.timer1_clock_select) |-> (ticks.t1 == pre_tick))
    else $error("timer 1 not on the prescaled clock");

  a_t0_pin_count : assert property (@(posedge clk) disable iff (!arst_n)
    mode_q.timer0_count_mode |-> (ticks.t0 == ev_fall[0]))
    else $error("timer 0 in count mode not driven by its pin");

  a_count_step : assert property (@(posedge clk) disable iff (!arst_n)
    (inc0 && !cnt_clr) |=> (cnt0_q == $past(cnt0_q) + COUNT_W'(1)))
    else $error("event tally did not advance by one");

  a_t2_rtc_src : assert property (@(posedge clk) disable iff (!arst_n)
    (!ctrl_q.timer2_low_clock_select &&
     mode_q.timer2_alternate_clock_choice == tcs_pkg::TCS_ALT_OSC8) |-> (ticks.t2_low == rtc8))
    else $error("timer 2 not on the real-time oscillator over eight");

  a_t3_cmp_src : assert property (@(posedge clk) disable iff (!arst_n)
    (!ctrl_q.timer3_low_clock_select &&
     mode_q.timer3_alternate_clock_choice == tcs_pkg::TCS_ALT_CMP) |-> (ticks.t3_low == ev_rise[5]))
    else $error("timer 3 not on comparator 1");

  a_t2_split_high : assert property (@(posedge clk) disable iff (!arst_n)
    (mode_q.timer2_split && ctrl_q.timer2_high_clock_select) |-> (ticks.t2_high == ce))
    else $error("timer 2 high byte not on the system clock");

  a_t3_whole : assert property (@(posedge clk) disable iff (!arst_n)
    !mode_q.timer3_split |-> (ticks.t3_high == ticks.t3_low))
    else $error("timer 3 high byte split from low byte in 16-bit mode");

  a_bus_answer : assert property (@(posedge clk) disable iff (!arst_n)
    (req && ce && !ack_q) |=> (!ce || !waitrequest || !req))
    else $error("bus access not answered after one wait cycle");

  // Main scenarios.
  c_t0_event : cover property (@(posedge clk) disable iff (!arst_n) inc0 ##[1:40] inc0);
  c_ext_prescale : cover property (@(posedge clk) disable iff (!arst_n)
    (ctrl_q.clock_divider_select == tcs_pkg::TCS_SCALE_EXT) && ticks.t0);
  c_t2_split_alt : cover property (@(posedge clk) disable iff (!arst_n)
    mode_q.timer2_split && !ctrl_q.timer2_high_clock_select && ticks.t2_high);
  c_ctrl_write : cover property (@(posedge clk) disable iff (!arst_n) wr_ctrl);

endmodule : tcs_timer_clock_select
`default_nettype wire

// File: test/tcs_event_source.sv
// Behavioural event source that drives the two timer event pins.
`timescale 1ns/10ps
`default_nettype none

module tcs_event_source (
  // Clock
  input  wire logic clk,
  // Event pins, idle high
  output var logic  pin0,
  output var logic  pin1
);
  // Pins idle high so that the first change of a burst is a falling edge.
  initial begin
    pin0 = 1'b1;
    pin1 = 1'b1;
  end

  // Drives n low-high pairs on one pin; each level is held for hold cycles, at least two.
  task automatic burst(input int sel, input int n, input int hold);
    int h;
    h = (hold < 2) ? 2 : hold;
    repeat (n) begin
      for (int lvl = 0; lvl < 2; lvl++) begin
        @(posedge clk);
        if (sel == 0) pin0 <= lvl[0];
        else pin1 <= lvl[0];
        repeat (h - 1) @(posedge clk);
      end
    end
  endtask : burst
endmodule : tcs_event_source
`default_nettype wire

// File: test/tcs_timer_clock_select_tb.sv
// Self-checking testbench of the timer clock selector.
`timescale 1ns/10ps
`default_nettype none

module tcs_timer_clock_select_tb;
  // Bench signals.
  logic        clk = 1'b0, arst_n = 1'b0, ce = 1'b1;
  logic [11:0] address = 12'h000;
  logic        read = 1'b0, write = 1'b0;
  logic [31:0] writedata = 32'h0, readdata, rd;
  logic [3:0]  byteenable = 4'hF;
  logic        waitrequest, pin0, pin1;
  logic        ext_osc = 1'b0, rtc_osc = 1'b0, cmp0 = 1'b0, cmp1 = 1'b0;
  logic [2:0]  ph = 3'h0;
  tcs_pkg::tcs_ticks_t ticks;
  logic [31:0] cnt [6];
  int          err_total = 0, check_count = 0, cyc = 0, waits = 0;

  tcs_timer_clock_select u_tcs_timer_clock_select (.clk(clk), .arst_n(arst_n), .ce(ce),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .timer0_event_pin(pin0), .timer1_event_pin(pin1), .ext_osc_clk(ext_osc),
    .rtc_osc_clk(rtc_osc), .cmp0_out(cmp0), .cmp1_out(cmp1), .ticks(ticks));

  tcs_event_source u_tcs_event_source (.clk(clk), .pin0(pin0), .pin1(pin1));

  initial begin
    forever #25 clk = ~clk;
  end

  // Slow sources toggle every fourth cycle, well under a quarter of the clock rate.
  always @(posedge clk) begin
    ph <= ph + 3'h1;
    if (ph[1:0] == 2'h3) begin
      ext_osc <= ~ext_osc;
      rtc_osc <= ~rtc_osc;
      cmp0    <= ~cmp0;
      cmp1    <= ~cmp1;
    end
  end

  // A hang is cut short well after the planned run of about 3700 cycles.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One Avalon transfer; the request stands until waitrequest is sampled low at a rising edge.
  // Read data is taken at that same edge; only the bench timeout ends a wait that never ends.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] be);
    @(posedge clk);
    address <= a;
    writedata <= d;
    byteenable <= be;
    if (w) write <= 1'b1;
    else read <= 1'b1;
    waits = 0;
    @(posedge clk);
    while (waitrequest !== 1'b0) begin
      waits++;
      @(posedge clk);
    end
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask : xfer

  // Counts each tick field over n settled cycles, t0 at index 5 down to t3_high at 0.
  task automatic measure(input int n);
    logic [5:0] tv;
    for (int i = 0; i < 6; i++) cnt[i] = 32'h0;
    repeat (n) begin
      @(negedge clk);
      tv = ticks;
      for (int i = 0; i < 6; i++) cnt[i] += {31'h0, tv[i]};
    end
  endtask : measure

  function automatic logic [31:0] in_range(input logic [31:0] v, input int lo, input int hi);
    return {31'h0, (v >= lo && v <= hi)};
  endfunction : in_range

  // Main sequence.
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    xfer(0, 12'h238, 32'h0, 4'hF);
    check(rd, 32'h00);
    // The slave answers after exactly one wait cycle.
    check(waits, 32'h1);
    xfer(0, 12'h23C, 32'h0, 4'hF);
    check(rd, 32'h00);
    xfer(1, 12'h100, 32'hFF, 4'hF);
    check(waits, 32'h1);
    xfer(0, 12'h100, 32'h0, 4'hF);
    check(rd, 32'h00);
    xfer(1, 12'h238, 32'hA5, 4'hE);
    xfer(0, 12'h238, 32'h0, 4'hF);
    check(rd, 32'h00);
    xfer(1, 12'h238, 32'hFF, 4'h1);
    xfer(0, 12'h238, 32'h0, 4'hF);
    check(rd, 32'hFF);
    // Prescale codes with Timer 1 on the system clock; 480 spans whole prescale periods.
    for (int c = 0; c < 3; c++) begin
      xfer(1, 12'h238, 32'h08 | c, 4'hF);
      measure(480);
      check(cnt[5], (c == 0) ? 40 : (c == 1) ? 120 : 10);
      check(cnt[4], 480);
      check(cnt[3], 40);
      check(cnt[2], 40);
      check(cnt[0], 40);
    end
    xfer(1, 12'h238, 32'h04, 4'hF);
    measure(480);
    check(cnt[5], 480);
    check(cnt[4], 40);
    // Oscillator sources, 60 rising edges in the window.
    xfer(1, 12'h238, 32'h03, 4'hF);
    xfer(1, 12'h23C, 32'h50, 4'hF);
    measure(480);
    check(in_range(cnt[5], 7, 8), 1);
    check(in_range(cnt[3], 7, 8), 1);
    check(in_range(cnt[1], 7, 8), 1);
    // Comparator sources with both timers split.
    xfer(1, 12'h238, 32'h60, 4'hF);
    xfer(1, 12'h23C, 32'hAC, 4'hF);
    measure(480);
    check(in_range(cnt[3], 59, 61), 1);
    check(cnt[2], 480);
    check(cnt[1], 480);
    check(in_range(cnt[0], 59, 61), 1);
    // Reserved alternate code falls back to the system clock over 12; other bytes on system clock.
    xfer(1, 12'h238, 32'h90, 4'hF);
    xfer(1, 12'h23C, 32'hFC, 4'hF);
    measure(480);
    check(cnt[3], 480);
    check(cnt[2], 40);
    check(cnt[1], 40);
    check(cnt[0], 480);
    // Event counting at the fastest legal rate; the select bits must be ignored.
    xfer(1, 12'h240, 32'h0, 4'hF);
    xfer(1, 12'h238, 32'h0C, 4'hF);
    xfer(1, 12'h23C, 32'h03, 4'hF);
    fork
      measure(200);
      begin
        u_tcs_event_source.burst(0, 10, 2);
        u_tcs_event_source.burst(1, 5, 3);
      end
    join
    check(cnt[5], 10);
    check(cnt[4], 5);
    xfer(0, 12'h240, 32'h0, 4'hF);
    check(rd, 32'h0005000A);
    xfer(1, 12'h240, 32'h0, 4'h0);
    xfer(0, 12'h240, 32'h0, 4'hF);
    check(rd, 32'h0);
    // A frozen block emits no ticks even on the system clock.
    xfer(1, 12'h23C, 32'h00, 4'hF);
    @(posedge clk);
    ce <= 1'b0;
    measure(48);
    check(cnt[5], 0);
    check(cnt[4], 0);
    @(posedge clk);
    ce <= 1'b1;
    print_verdict();
  end
endmodule : tcs_timer_clock_select_tb
`default_nettype wire
